// *** rtl/fbcd_defines.svh ***
// Constants for the parallel flash bus command host controller.
`ifndef FBCD_DEFINES_SVH
`define FBCD_DEFINES_SVH
// AXI4-Lite register byte offsets.
`define FBCD_REG_CTRL   5'h00
`define FBCD_REG_ADDR   5'h04
`define FBCD_REG_WDATA  5'h08
`define FBCD_REG_STATUS 5'h0c
`define FBCD_REG_RDATA  5'h10
// Control register field positions.
`define FBCD_CTRL_GO    0
`define FBCD_CTRL_CMD_LO 1
`define FBCD_CTRL_CMD_HI 4
`define FBCD_CTRL_HVID  8
// Command codes written into the control register.
`define FBCD_OP_READ    4'h0
`define FBCD_OP_RESET1  4'h1
`define FBCD_OP_RESET4  4'h2
`define FBCD_OP_IDENT   4'h3
`define FBCD_OP_PROG    4'h4
`define FBCD_OP_CHIPER  4'h5
`define FBCD_OP_SECTER  4'h6
`define FBCD_OP_SUSP    4'h7
`define FBCD_OP_RESUME  4'h8
`define FBCD_OP_WRITE1  4'h9
// Flash command bytes and unlock addresses.
`define FBCD_UNLOCK_A1  19'h05555
`define FBCD_UNLOCK_A2  19'h02aaa
`define FBCD_UNLOCK_D1  8'haa
`define FBCD_UNLOCK_D2  8'h55
`define FBCD_CB_RESET   8'hf0
`define FBCD_CB_IDENT   8'h90
`define FBCD_CB_PROG    8'ha0
`define FBCD_CB_ERASE   8'h80
`define FBCD_CB_CHIP    8'h10
`define FBCD_CB_SECTOR  8'h30
`define FBCD_CB_SUSP    8'hb0
// Bus phase lengths in ns and derived clock counts at 20 MHz.
`define FBCD_CLK_NS     50
`define FBCD_T_SETUP_NS 50
`define FBCD_T_PULSE_NS 100
`define FBCD_T_READ_NS  150
`define FBCD_SETUP_CYC  ((`FBCD_T_SETUP_NS+`FBCD_CLK_NS-1)/`FBCD_CLK_NS)
`define FBCD_PULSE_CYC  ((`FBCD_T_PULSE_NS+`FBCD_CLK_NS-1)/`FBCD_CLK_NS)
`define FBCD_READ_CYC   ((`FBCD_T_READ_NS+`FBCD_CLK_NS-1)/`FBCD_CLK_NS)
`endif

// *** rtl/fbcd_pkg.sv ***
// Types for the parallel flash bus command host controller.
package fbcd_pkg;
  typedef enum logic [5:0] {
    FBCD_IDLE  = 6'h01,
    FBCD_SETUP = 6'h02,
    FBCD_PULSE = 6'h04,
    FBCD_HOLD  = 6'h08,
    FBCD_READ  = 6'h10,
    FBCD_NEXT  = 6'h20
  } fbcd_state_t;
endpackage

// *** rtl/fbcd_host.sv ***
// Host controller that drives the flash command bus from AXI4-Lite orders.
//
// Notes on behaviour
// - Write cycle: select low, gate high, strobe pulsed low by host.
// - Read cycle: select and gate low, strobe high throughout.
// - Reset is one F0 write anywhere, or unlock pair then F0 at 5555.
// - Multi-write commands begin with AA at 5555 then 55 at 2AAA.
// - Program is unlock pair, A0 at 5555, then target address and byte.
// - Sector erase is unlock, 80, unlock, then 30 at the sector address.
// - B0 anywhere suspends sector erase, 30 anywhere resumes it.
`timescale 1ns/1ps
`include "fbcd_defines.svh"

module fbcd_host (
  // Clock and reset.
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address channel.
  input  wire logic [4:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data channel.
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response channel.
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address channel.
  input  wire logic [4:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data channel.
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Flash bus pins.
  output logic [18:0]      flash_addr,
  output logic             flash_select_n,
  output logic             flash_gate_n,
  output logic             flash_strobe_n,
  output logic [7:0]       flash_dq_o,
  output logic             flash_dq_oe,
  input  wire logic [7:0]  flash_dq_i,
  output logic             hv_identifier_pin
);

  // ------------------------------------------------------------------
  // Registers and state.
  // ------------------------------------------------------------------
  fbcd_pkg::fbcd_state_t state_ff;
  logic [3:0]  op_ff;
  logic        hvid_ff;
  logic [18:0] addr_reg_ff;
  logic [7:0]  wdata_reg_ff;
  logic [7:0]  rdata_ff;
  logic        busy_ff;
  logic        done_ff;
  logic [2:0]  step_ff;
  logic [2:0]  cnt_ff;
  logic [7:0]  dq_sync1_ff;
  logic [7:0]  dq_sync2_ff;
  logic        aw_got_ff;
  logic        w_got_ff;
  logic [4:0]  awaddr_ff;
  logic [31:0] wdata_ff;
  logic [2:0]  nsteps;
  logic [18:0] step_addr;
  logic [7:0]  step_data;
  logic        step_is_read;
  logic        wr_fire;
  logic        go;

  // ------------------------------------------------------------------
  // AXI4-Lite slave.
  // ------------------------------------------------------------------
  // Address and data are taken in either order, then answered together.
  assign s_axi_awready = !aw_got_ff && !s_axi_bvalid;
  assign s_axi_wready  = !w_got_ff && !s_axi_bvalid;
  assign wr_fire       = aw_got_ff && w_got_ff && !s_axi_bvalid;
  assign s_axi_bresp   = 2'h0;
  assign s_axi_rresp   = 2'h0;
  assign s_axi_arready = !s_axi_rvalid;

  // Captures write address and data and issues the response.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_ff    <= 1'b0;
      w_got_ff     <= 1'b0;
      awaddr_ff    <= 5'h00;
      wdata_ff     <= 32'h0;
      s_axi_bvalid <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        aw_got_ff    <= 1'b0;
        w_got_ff     <= 1'b0;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // A start request is only honoured while the bus engine is idle.
  assign go = wr_fire && (awaddr_ff == `FBCD_REG_CTRL) &&
              wdata_ff[`FBCD_CTRL_GO] && !busy_ff;

  // Writable registers: control, address and data.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      op_ff        <= `FBCD_OP_READ;
      hvid_ff      <= 1'b0;
      addr_reg_ff  <= 19'h0;
      wdata_reg_ff <= 8'h00;
    end else if (wr_fire) begin
      if (awaddr_ff == `FBCD_REG_CTRL) begin
        if (!busy_ff)
          op_ff <= wdata_ff[`FBCD_CTRL_CMD_HI:`FBCD_CTRL_CMD_LO];
        hvid_ff <= wdata_ff[`FBCD_CTRL_HVID];
      end else if (awaddr_ff == `FBCD_REG_ADDR) begin
        addr_reg_ff <= wdata_ff[18:0];
      end else if (awaddr_ff == `FBCD_REG_WDATA) begin
        wdata_reg_ff <= wdata_ff[7:0];
      end
    end
  end

  // Read channel with zero for unmapped offsets.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      if (s_axi_araddr == `FBCD_REG_CTRL)
        s_axi_rdata <= {23'h0, hvid_ff, 3'h0, op_ff, 1'b0};
      else if (s_axi_araddr == `FBCD_REG_ADDR)
        s_axi_rdata <= {13'h0, addr_reg_ff};
      else if (s_axi_araddr == `FBCD_REG_WDATA)
        s_axi_rdata <= {24'h0, wdata_reg_ff};
      else if (s_axi_araddr == `FBCD_REG_STATUS)
        s_axi_rdata <= {30'h0, done_ff, busy_ff};
      else if (s_axi_araddr == `FBCD_REG_RDATA)
        s_axi_rdata <= {24'h0, rdata_ff};
      else
        s_axi_rdata <= 32'h0;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Sequence tables.
  // ------------------------------------------------------------------
  // Picks the address, data and direction of each bus cycle.
  always_comb begin
    nsteps       = 3'd1;
    step_addr    = `FBCD_UNLOCK_A1;
    step_data    = `FBCD_UNLOCK_D1;
    step_is_read = 1'b0;
    // Unlock pair opens every multi-write sequence.
    if (step_ff == 3'd1 || step_ff == 3'd4) begin
      step_addr = `FBCD_UNLOCK_A2;
      step_data = `FBCD_UNLOCK_D2;
    end
    case (op_ff)
      `FBCD_OP_READ: begin
        step_addr    = addr_reg_ff;
        step_is_read = 1'b1;
      end
      `FBCD_OP_RESET1: begin
        step_addr = addr_reg_ff;
        step_data = `FBCD_CB_RESET;
      end
      `FBCD_OP_RESET4: begin
        nsteps = 3'd3;
        if (step_ff == 3'd2) step_data = `FBCD_CB_RESET;
      end
      `FBCD_OP_IDENT: begin
        nsteps = 3'd3;
        if (step_ff == 3'd2) step_data = `FBCD_CB_IDENT;
      end
      `FBCD_OP_PROG: begin
        nsteps = 3'd4;
        if (step_ff == 3'd2) step_data = `FBCD_CB_PROG;
        if (step_ff == 3'd3) begin
          step_addr = addr_reg_ff;
          step_data = wdata_reg_ff;
        end
      end
      `FBCD_OP_CHIPER, `FBCD_OP_SECTER: begin
        nsteps = 3'd6;
        if (step_ff == 3'd2) step_data = `FBCD_CB_ERASE;
        if (step_ff == 3'd5) begin
          if (op_ff == `FBCD_OP_CHIPER) begin
            step_data = `FBCD_CB_CHIP;
          end else begin
            step_addr = addr_reg_ff;
            step_data = `FBCD_CB_SECTOR;
          end
        end
      end
      `FBCD_OP_SUSP: begin
        step_addr = addr_reg_ff;
        step_data = `FBCD_CB_SUSP;
      end
      `FBCD_OP_RESUME: begin
        step_addr = addr_reg_ff;
        step_data = `FBCD_CB_SECTOR;
      end
      default: begin // Raw single write of the data register.
        step_addr = addr_reg_ff;
        step_data = wdata_reg_ff;
      end
    endcase
  end

  // ------------------------------------------------------------------
  // Flash bus engine.
  // ------------------------------------------------------------------
  // Runs setup, strobe and hold phases per write cycle and read then hold per read; the bus is released
  // between cycles so a deselected device simply finishes its work.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff       <= fbcd_pkg::FBCD_IDLE;
      step_ff        <= 3'd0;
      cnt_ff         <= 3'd0;
      busy_ff        <= 1'b0;
      done_ff        <= 1'b0;
      rdata_ff       <= 8'h00;
      flash_addr     <= 19'h0;
      flash_select_n <= 1'b1;
      flash_gate_n   <= 1'b1;
      flash_strobe_n <= 1'b1;
      flash_dq_o     <= 8'h00;
      flash_dq_oe    <= 1'b0;
    end else begin
      case (state_ff)
        fbcd_pkg::FBCD_IDLE: begin
          if (go) begin
            busy_ff  <= 1'b1;
            done_ff  <= 1'b0;
            step_ff  <= 3'd0;
            state_ff <= fbcd_pkg::FBCD_NEXT;
          end
        end
        fbcd_pkg::FBCD_NEXT: begin
          flash_addr     <= step_addr;
          flash_select_n <= 1'b0;
          flash_gate_n   <= !step_is_read;
          flash_dq_o     <= step_data;
          flash_dq_oe    <= !step_is_read;
          cnt_ff         <= 3'd0;
          state_ff       <= step_is_read ? fbcd_pkg::FBCD_READ
                                         : fbcd_pkg::FBCD_SETUP;
        end
        fbcd_pkg::FBCD_SETUP: begin
          cnt_ff <= cnt_ff + 3'd1;
          if (cnt_ff == 3'(`FBCD_SETUP_CYC - 1)) begin
            flash_strobe_n <= 1'b0;
            cnt_ff         <= 3'd0;
            state_ff       <= fbcd_pkg::FBCD_PULSE;
          end
        end
        fbcd_pkg::FBCD_PULSE: begin
          cnt_ff <= cnt_ff + 3'd1;
          if (cnt_ff == 3'(`FBCD_PULSE_CYC - 1)) begin
            flash_strobe_n <= 1'b1;
            state_ff       <= fbcd_pkg::FBCD_HOLD;
          end
        end
        fbcd_pkg::FBCD_READ: begin
          cnt_ff <= cnt_ff + 3'd1;
          // Two extra cycles cover the data synchroniser.
          if (cnt_ff == 3'(`FBCD_READ_CYC + 1)) begin
            rdata_ff <= dq_sync2_ff;
            state_ff <= fbcd_pkg::FBCD_HOLD;
          end
        end
        default: begin // Hold: release the bus, then next step or done.
          flash_select_n <= 1'b1;
          flash_gate_n   <= 1'b1;
          flash_dq_oe    <= 1'b0;
          if (step_ff == nsteps - 3'd1) begin
            busy_ff  <= 1'b0;
            done_ff  <= 1'b1;
            state_ff <= fbcd_pkg::FBCD_IDLE;
          end else begin
            step_ff  <= step_ff + 3'd1;
            state_ff <= fbcd_pkg::FBCD_NEXT;
          end
        end
      endcase
    end
  end

  // Two-stage synchroniser for the data pins.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dq_sync1_ff <= 8'h00;
      dq_sync2_ff <= 8'h00;
    end else begin
      dq_sync1_ff <= flash_dq_i;
      dq_sync2_ff <= dq_sync1_ff;
    end
  end

  // High-voltage identifier request straight from the control register.
  assign hv_identifier_pin = hvid_ff;

endmodule // fbcd_host

// *** test/fbcd_host_monitor.sv ***
// Checker of the flash bus pins that the host controller drives.
`timescale 1ns/1ps
module fbcd_host_monitor (
  // Clock and reset.
  input wire logic        aclk,
  input wire logic        aresetn,
  // Flash bus pins.
  input wire logic [18:0] flash_addr,
  input wire logic        flash_select_n,
  input wire logic        flash_gate_n,
  input wire logic        flash_strobe_n,
  input wire logic [7:0]  flash_dq_o,
  input wire logic        flash_dq_oe
);
  // ------------------------------------------------------------
  // Bus cycle shape
  // ------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // A strobe pulse only happens inside a selected, driven write.
  property p_wr_pins; !flash_strobe_n |->
    !flash_select_n && flash_gate_n && flash_dq_oe; endproperty
  a_wr_pins: assert property (p_wr_pins)
    else $error("strobe low outside a selected write");
  property p_wr_hold; !flash_strobe_n |->
    $stable(flash_addr) && $stable(flash_dq_o); endproperty
  a_wr_hold: assert property (p_wr_hold)
    else $error("address or data moved under the strobe");
  // The strobe stays low for exactly two cycles.
  property p_pulse; $fell(flash_strobe_n) |->
    !flash_strobe_n [*2] ##1 flash_strobe_n; endproperty
  a_pulse: assert property (p_pulse)
    else $error("strobe pulse length wrong");
  property p_setup; $fell(flash_strobe_n) |->
    !$past(flash_select_n) && $past(flash_dq_oe); endproperty
  a_setup: assert property (p_setup)
    else $error("no setup cycle before the strobe");
  // Data is still driven at the rising strobe that takes it.
  property p_data_end; $rose(flash_strobe_n) |->
    !flash_select_n && flash_dq_oe && $stable(flash_dq_o); endproperty
  a_data_end: assert property (p_data_end)
    else $error("data released before the strobe rose");
  property p_rd_pins; !flash_gate_n |->
    !flash_select_n && flash_strobe_n && !flash_dq_oe; endproperty
  a_rd_pins: assert property (p_rd_pins)
    else $error("bad pin levels in a read");
  property p_rd_len; $fell(flash_gate_n) |-> !flash_gate_n ##1
    (!flash_gate_n && $stable(flash_addr)) [*4]; endproperty
  a_rd_len: assert property (p_rd_len)
    else $error("read cycle too short");
  property p_idle; flash_select_n |->
    !flash_dq_oe && flash_strobe_n; endproperty
  a_idle: assert property (p_idle)
    else $error("bus active while deselected");
endmodule // fbcd_host_monitor

bind fbcd_host fbcd_host_monitor i_mon (
  .aclk, .aresetn, .flash_addr, .flash_select_n, .flash_gate_n,
  .flash_strobe_n, .flash_dq_o, .flash_dq_oe);

// *** test/fbcd_flash_model.sv ***
// Behavioural model of the byte-wide flash device on the host bus.
`timescale 1ns/1ps
module fbcd_flash_model #(
  parameter logic [7:0] MAKER_CODE = 8'h5a, // Arbitrary value.
  parameter logic [7:0] PART_CODE  = 8'hc3, // Arbitrary value.
  parameter logic [7:0] PROT_MASK  = 8'h20
) (
  // Bus pins from the host.
  input  wire logic [18:0] flash_addr,
  input  wire logic        flash_select_n,
  input  wire logic        flash_gate_n,
  input  wire logic        flash_strobe_n,
  input  wire logic [7:0]  flash_dq_o,
  input  wire logic        flash_dq_oe,
  input  wire logic        hv_identifier_pin,
  // Data level seen by the host.
  output logic [7:0]       flash_dq_i
);
  // ------------------------------------------------------------
  // Command decoding
  // ------------------------------------------------------------
  logic [7:0]  mem [0:20'h7ffff];
  logic [18:0] lat_addr = 19'h00000;
  logic [1:0]  seq = 2'h0;
  logic [1:0]  nxt;
  logic        erase_setup = 1'h0;
  logic        ident_mode = 1'h0;
  logic        prog_armed = 1'h0;
  logic        suspended = 1'h0;
  logic [7:0]  rd_val;
  logic [7:0]  last_v = 8'h00;
  wire         u1 = lat_addr[14:0] == 15'h5555;
  wire         u2 = lat_addr[14:0] == 15'h2aaa;
  wire         drv = !flash_select_n && !flash_gate_n && flash_strobe_n;
  // Erase is instant here, so deselecting never cuts it short.
  task automatic erase(input logic all, input logic [2:0] sec);
    for (int i = 0; i < 20'h80000; i++)
      if (all || i[18:16] == sec) mem[i] = 8'hff;
  endtask
  // Power-up lands in read mode with an erased array.
  initial erase(1'h1, 3'h0);
  // The address is taken as the strobe falls.
  always @(negedge flash_strobe_n)
    if (!flash_select_n) lat_addr = flash_addr;
  // Data is taken and decoded as the strobe rises.
  always @(posedge flash_strobe_n) begin
    nxt = 2'h0;
    if (!flash_select_n && flash_gate_n) begin
      if (prog_armed) begin
        mem[lat_addr] = mem[lat_addr] & flash_dq_o;
        prog_armed = 1'h0;
      end else if (flash_dq_o == 8'hf0) begin
        ident_mode = 1'h0;
        erase_setup = 1'h0;
      end else if (seq == 2'h0 && flash_dq_o == 8'hb0)
        suspended = 1'h1;
      else if (seq == 2'h0 && flash_dq_o == 8'h30)
        suspended = 1'h0;
      else if (seq == 2'h0 && u1 && flash_dq_o == 8'haa)
        nxt = 2'h1;
      else if (seq == 2'h1 && u2 && flash_dq_o == 8'h55)
        nxt = 2'h2;
      else if (seq == 2'h2 && erase_setup &&
               (u1 && flash_dq_o == 8'h10 || flash_dq_o == 8'h30)) begin
        erase(flash_dq_o == 8'h10, lat_addr[18:16]);
        erase_setup = 1'h0;
      end else if (seq == 2'h2 && u1 && flash_dq_o == 8'h90)
        ident_mode = 1'h1;
      else if (seq == 2'h2 && u1 && flash_dq_o == 8'ha0)
        prog_armed = 1'h1;
      else if (seq == 2'h2 && u1 && flash_dq_o == 8'h80)
        erase_setup = 1'h1;
      else
        erase_setup = 1'h0;
      seq = nxt;
    end
  end
  // Read data is an identifier code or the array byte.
  always @* begin
    rd_val = mem[flash_addr];
    if (ident_mode || hv_identifier_pin)
      case ({flash_addr[6], flash_addr[1:0]})
        3'h0: rd_val = MAKER_CODE;
        3'h1: rd_val = PART_CODE;
        3'h2: rd_val = {7'h00, PROT_MASK[flash_addr[18:16]]};
        default: ;
      endcase
  end
  // Undriven lines show the inverse of the last driven level.
  assign flash_dq_i = flash_dq_oe ? flash_dq_o : drv ? rd_val : ~last_v;
  always @(flash_dq_i)
    if (flash_dq_oe || drv) last_v = flash_dq_i;
endmodule // fbcd_flash_model

// *** test/tb_top.sv ***
// Self-checking bench for the flash bus host controller.
`timescale 1ns/1ps
`include "fbcd_defines.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin failures++; \
  $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module tb_top;
  // ------------------------------------------------------------
  // Signals, clock and units
  // ------------------------------------------------------------
  localparam logic [7:0] MAKER_CODE = 8'h5a; // Arbitrary value.
  localparam logic [7:0] PART_CODE  = 8'hc3; // Arbitrary value.
  localparam logic [7:0] PROT_MASK  = 8'h20;
  logic        aclk = 1'h0, aresetn = 1'h0;
  logic [4:0]  s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_bready = 1'h1, s_axi_rready = 1'h1;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, flash_select_n, flash_gate_n, flash_strobe_n;
  logic        flash_dq_oe, hv_identifier_pin;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [18:0] flash_addr;
  logic [7:0]  flash_dq_o, flash_dq_i;
  int          failures = 0, checks = 0;
  always #25 aclk = ~aclk;
  fbcd_host i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .flash_addr, .flash_select_n, .flash_gate_n, .flash_strobe_n,
    .flash_dq_o, .flash_dq_oe, .flash_dq_i, .hv_identifier_pin);
  fbcd_flash_model #(.MAKER_CODE(MAKER_CODE), .PART_CODE(PART_CODE),
    .PROT_MASK(PROT_MASK)) i_flash (.flash_addr, .flash_select_n,
    .flash_gate_n, .flash_strobe_n, .flash_dq_o, .flash_dq_oe,
    .hv_identifier_pin, .flash_dq_i);
  // ------------------------------------------------------------
  // Bus tasks and row table
  // ------------------------------------------------------------
  // Offers address and data together and waits for the response.
  task automatic axi_wr(input logic [4:0] a, input logic [31:0] d);
    logic aw_left, w_left, t;
    logic [1:0] resp;
    aw_left = 1'h1;
    w_left = 1'h1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    while (aw_left || w_left) begin
      @(negedge aclk);
      t = s_axi_awready;
      w_left = w_left && !s_axi_wready;
      @(posedge aclk);
      aw_left = aw_left && !t;
      s_axi_awvalid <= aw_left;
      s_axi_wvalid <= w_left;
    end
    do begin
      @(negedge aclk);
      t = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge aclk);
    end while (!t);
    `CHK(resp, 2'h0)
  endtask
  task automatic axi_rd(input logic [4:0] a, output logic [31:0] d);
    logic t;
    logic [1:0] resp;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do begin
      @(negedge aclk);
      t = s_axi_arready;
      @(posedge aclk);
    end while (!t);
    s_axi_arvalid <= 1'h0;
    do begin
      @(negedge aclk);
      t = s_axi_rvalid;
      d = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge aclk);
    end while (!t);
    `CHK(resp, 2'h0)
  endtask
  // Row: op, high-voltage flag, address, write byte, expected read byte.
  task automatic flash_op(input logic [43:0] r, output logic [7:0] rd);
    logic [31:0] st;
    axi_wr(`FBCD_REG_ADDR, {13'h0, r[34:16]});
    axi_wr(`FBCD_REG_WDATA, {24'h0, r[15:8]});
    axi_wr(`FBCD_REG_CTRL, {23'h0, r[36], 3'h0, r[43:40], 1'h1});
    do axi_rd(`FBCD_REG_STATUS, st); while (st[1:0] !== 2'h2);
    axi_rd(`FBCD_REG_RDATA, st);
    rd = st[7:0];
  endtask
  task automatic stop_test();
    $display("failures %0d checks %0d", failures, checks);
    if (failures == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  logic [43:0] rows [0:30] = '{44'h00_00100_00ff, 44'h40_12345_3c00,
    44'h00_12345_003c, 44'h30_00000_0000, {36'h000000000, MAKER_CODE},
    {36'h000000100, PART_CODE}, {36'h005000200, 7'h00, PROT_MASK[5]},
    {36'h003000200, 7'h00, PROT_MASK[3]}, 44'h10_7fff0_0000,
    44'h00_00000_00ff, 44'h30_00000_0000, 44'h20_00000_0000,
    44'h00_12345_003c, 44'h50_00000_0000, 44'h00_12345_00ff,
    44'h40_23456_1100, 44'h40_33456_2200, 44'h60_2ffff_0000,
    44'h00_23456_00ff, 44'h00_33456_0022, 44'h90_7d555_aa00,
    44'h90_7aaaa_5500, 44'h90_45555_9000, {36'h000000100, PART_CODE},
    44'h10_00000_0000, 44'h90_05555_aa00, 44'h90_02aaa_7700,
    44'h90_05555_9000, 44'h00_00000_00ff, {36'h010000100, PART_CODE},
    44'h00_00001_00ff};
  // ------------------------------------------------------------
  // Main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    logic [7:0]  rd;
    logic [31:0] w;
    repeat (10) @(posedge aclk);
    `CHK({flash_select_n, flash_dq_oe}, 2'h2)
    aresetn <= 1'h1;
    foreach (rows[i]) begin
      flash_op(rows[i], rd);
      if (rows[i][43:40] == 4'h0)
        `CHK(rd, rows[i][7:0])
    end
    // Suspend then resume, each a single write anywhere.
    flash_op(44'h70_20000_0000, rd);
    `CHK(i_flash.suspended, 1'h1)
    flash_op(44'h80_20000_0000, rd);
    `CHK(i_flash.suspended, 1'h0)
    // A start while busy is ignored, op field and all.
    axi_wr(`FBCD_REG_CTRL, {27'h0, 4'h0, 1'h1});
    axi_wr(`FBCD_REG_CTRL, {27'h0, 4'h9, 1'h1});
    do axi_rd(`FBCD_REG_STATUS, w); while (w[1:0] !== 2'h2);
    axi_rd(`FBCD_REG_CTRL, w);
    `CHK(w, 32'h0)
    axi_rd(`FBCD_REG_RDATA, w);
    `CHK(w, 32'h0000_00ff)
    // An unmapped register reads as zero.
    axi_rd(5'h14, w);
    `CHK(w, 32'h0)
    // A reset in the middle of a chip erase sequence idles the bus.
    axi_wr(`FBCD_REG_CTRL, {27'h0, 4'h5, 1'h1});
    aresetn <= 1'h0;
    repeat (3) @(posedge aclk);
    `CHK({flash_select_n, flash_strobe_n, flash_dq_oe}, 3'h6)
    aresetn <= 1'h1;
    axi_rd(`FBCD_REG_STATUS, w);
    `CHK(w[1:0], 2'h0)
    flash_op(44'h00_33456_0000, rd);
    `CHK(rd, 8'h22)
    stop_test();
  end
  initial begin
    repeat (20000) @(posedge aclk);
    failures++;
    stop_test();
  end
endmodule // tb_top
